// >>> core/sram_pkg.sv
package sram_pkg;
  // Widths and depth of the array.
  localparam int ADDR_W    = 10;
  localparam int LANES     = 4;
  localparam int LANE_W    = 9;
  localparam int DATA_W    = LANES * LANE_W;
  localparam int BURST_W   = 2;
  // Cycles from sleep request edge to sleep entry and exit.
  localparam int SLEEP_DLY = 2;
  // Values after reset.
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h0;
  // Kind of access held in a pipeline stage.
  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_t;
endpackage

// >>> core/burst_counter.sv
`timescale 1ns/1ps
module burst_counter
  import sram_pkg::*;
(
  // Clock and reset.
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // Control.
  input  wire logic               step_en,
  input  wire logic               load,
  input  wire logic [BURST_W-1:0] low_addr_bits,
  input  wire logic               linear_order_sel_n,
  // Burst address.
  output logic      [BURST_W-1:0] burst_addr
);
  logic [BURST_W-1:0] start;
  logic [BURST_W-1:0] count;

  // Start value is preset by the low address bits; the count wraps after four.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      start <= '0;
      count <= '0;
    end else if (load) begin
      // The load edge uses the external address, so the first advance is one step on.
      start <= low_addr_bits;
      count <= 2'h1;
    end else if (step_en) begin
      count <= count + 2'h1;
    end
  end

  // Linear adds the count, interleaved XORs it in.
  assign burst_addr = linear_order_sel_n ? (start ^ count) : (start + count);
endmodule

// >>> core/sleep_ctrl.sv
`timescale 1ns/1ps
module sleep_ctrl
  import sram_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic reset,
  // Request and state.
  input  wire logic sleep_request,
  output logic      asleep
);
  logic [SLEEP_DLY-1:0] delay;

  // The request is delayed two cycles before it takes effect either way.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      delay <= '0;
    end else begin
      delay <= {delay[SLEEP_DLY-2:0], sleep_request};
    end
  end

  assign asleep = delay[SLEEP_DLY-1];
endmodule

// >>> core/sync_late_write_sram_port.sv
`timescale 1ns/1ps
// How it works
// - Inactive clock gate freezes every internal operation except the sleep delay and the bus release while asleep.
// - Control inputs sampled on the rising edge.
// - Selected only with all three selects active.
// - Read start captures the external address.
// - Pipelined read data appears two cycles later.
// - Write starts when selected, write strobe low.
// - Each lane strobe enables its nine bits.
// - Write with no lanes changes nothing.
// - Pipelined write data taken at third edge.
// - Flow-through read data arrives one cycle sooner.
// - Flow-through write data taken at second edge.
// - Read to write needs no idle cycles.
// - Burst and read start identical in both modes.
// - Low address bits preset burst counter.
// - Pin polarities as listed for each input.
// - Mode select picks flow-through or pipelined.
// - Sleep active high, linear order active low.
// - Advance high steps the burst counter.
// - Two-bit counter, linear or interleaved, wraps.
// - Sleep entry and exit two cycles delayed.
// - Stalled pipelined read keeps bus driven.
module sync_late_write_sram_port
  import sram_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  // Clock and reset.
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  // Command inputs.
  input  wire logic                         clock_gate_n,
  input  wire logic                         advance_load,
  input  wire logic                         write_n,
  input  wire logic                         chip_select_first_n,
  input  wire logic                         chip_select_second,
  input  wire logic                         chip_select_third_n,
  input  wire logic [AW-1:0]                addr,
  input  wire logic                         lane_strobe_first_n,
  input  wire logic                         lane_strobe_second_n,
  input  wire logic                         lane_strobe_third_n,
  input  wire logic                         lane_strobe_fourth_n,
  // Mode and asynchronous inputs.
  input  wire logic                         flow_mode_sel_n,
  input  wire logic                         linear_order_sel_n,
  input  wire logic                         sleep_request,
  input  wire logic                         output_enable_n,
  // Data bus as three signals.
  input  wire logic [sram_pkg::DATA_W-1:0]  data_in,
  output logic      [sram_pkg::DATA_W-1:0]  data_out,
  output logic                              data_oe
);
  import sram_pkg::*;

  logic [DATA_W-1:0] mem [0:(1<<AW)-1];
  logic              clk_on;
  logic              selected;
  logic              asleep;
  logic              load;
  logic              step;
  logic [LANES-1:0]  lanes_n;
  logic [BURST_W-1:0] burst_addr;
  logic [AW-1:0]     base_addr;
  logic [AW-1:0]     eff_addr;
  logic              burst_active;
  logic              burst_write;
  op_t               next_op;
  op_t               op1;
  op_t               op2;
  logic [AW-1:0]     addr1;
  logic [AW-1:0]     addr2;
  logic [LANES-1:0]  lanes1;
  logic [LANES-1:0]  lanes2;
  logic [DATA_W-1:0] read_word;
  logic [DATA_W-1:0] out_reg;
  logic              drive_reg;

  assign lanes_n = {lane_strobe_fourth_n, lane_strobe_third_n,
                    lane_strobe_second_n, lane_strobe_first_n};

  // Edges count only with the gate low and the device awake.
  assign clk_on   = !clock_gate_n && !asleep;
  assign selected = !chip_select_first_n && chip_select_second
                    && !chip_select_third_n;
  assign load     = clk_on && !advance_load;
  assign step     = clk_on && advance_load && burst_active;

  sleep_ctrl u_sleep (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .sleep_request (sleep_request),
    .asleep        (asleep)
  );

  burst_counter u_burst (
    .ref_clk            (ref_clk),
    .reset              (reset),
    .step_en            (step),
    .load               (load && selected),
    .low_addr_bits      (addr[BURST_W-1:0]),
    .linear_order_sel_n (linear_order_sel_n),
    .burst_addr         (burst_addr)
  );

  // Burst state remembers the loaded address and the access kind.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      base_addr    <= ADDR_RST;
      burst_active <= 1'b0;
      burst_write  <= 1'b0;
    end else if (load) begin
      base_addr    <= addr;
      burst_active <= selected;
      burst_write  <= !write_n;
    end
  end

  // Address of the current command: external on load, counter on advance.
  assign eff_addr = load ? addr : {base_addr[AW-1:BURST_W], burst_addr};

  // Classify the command sampled on this edge.
  always_comb begin
    next_op = OP_IDLE;
    if (load && selected) begin
      next_op = write_n ? OP_READ : OP_WRITE;
    end else if (step) begin
      next_op = burst_write ? OP_WRITE : OP_READ;
    end
  end

  // Command pipeline; stage one is the registered command.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      op1    <= OP_IDLE;
      op2    <= OP_IDLE;
      addr1  <= ADDR_RST;
      addr2  <= ADDR_RST;
      lanes1 <= '1;
      lanes2 <= '1;
    end else if (clk_on) begin
      op1    <= next_op;
      addr1  <= eff_addr;
      lanes1 <= lanes_n;
      op2    <= op1;
      addr2  <= addr1;
      lanes2 <= lanes1;
    end
  end

  // Late write: data sampled one edge after the command in flow-through,
  // two edges after in pipelined mode, matching read latency.
  always_ff @(posedge ref_clk) begin
    if (clk_on) begin
      if (!flow_mode_sel_n && op1 == OP_WRITE) begin
        for (int i = 0; i < LANES; i++) begin
          if (!lanes1[i]) begin
            mem[addr1][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
          end
        end
      end
      if (flow_mode_sel_n && op2 == OP_WRITE) begin
        for (int i = 0; i < LANES; i++) begin
          if (!lanes2[i]) begin
            mem[addr2][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

  assign read_word = mem[addr1];

  // Output register: flow-through loads it from the array at the command
  // edge, pipelined one edge later from the stage-one address.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      out_reg   <= DATA_RST;
      drive_reg <= 1'b0;
    end else if (clk_on) begin
      if (!flow_mode_sel_n) begin
        drive_reg <= (next_op == OP_READ);
        if (next_op == OP_READ) begin
          out_reg <= mem[eff_addr];
        end
      end else begin
        drive_reg <= (op1 == OP_READ);
        if (op1 == OP_READ) begin
          out_reg <= read_word;
        end
      end
    end else if (asleep) begin
      drive_reg <= 1'b0;
    end
  end

  assign data_out = out_reg;
  // Output enable cuts the drivers at once, independent of the clock.
  assign data_oe  = drive_reg && !output_enable_n;

  // Checks on the command pipeline, the data bus and sleep entry.
  a_oe_async: assert property (@(posedge ref_clk) disable iff (reset)
    output_enable_n |-> !data_oe)
    else $error("data bus driven with output enable inactive");
  a_gate_freeze: assert property (@(posedge ref_clk) disable iff (reset)
    (clock_gate_n && !asleep) |=> ($stable(op1) && $stable(addr1)))
    else $error("pipeline moved on a gated edge");
  a_pipe_read: assert property (@(posedge ref_clk) disable iff (reset)
    (flow_mode_sel_n && next_op == OP_READ) ##1 (clk_on && flow_mode_sel_n)
    |=> drive_reg)
    else $error("pipelined read data not driven after two edges");
  a_flow_read: assert property (@(posedge ref_clk) disable iff (reset)
    (!flow_mode_sel_n && next_op == OP_READ) |=> drive_reg)
    else $error("flow-through read data not driven after one edge");
  a_write_no_drive: assert property (@(posedge ref_clk) disable iff (reset)
    (clk_on && next_op == OP_WRITE && !flow_mode_sel_n) |=> !drive_reg)
    else $error("bus driven during a write data cycle");
  a_deselect_idle: assert property (@(posedge ref_clk) disable iff (reset)
    (load && !selected) |=> op1 == OP_IDLE)
    else $error("deselected command entered the pipeline");
  a_read_start: assert property (@(posedge ref_clk) disable iff (reset)
    (load && selected && write_n) |=> (op1 == OP_READ && addr1 == $past(addr)))
    else $error("read start did not capture the address");
  a_write_start: assert property (@(posedge ref_clk) disable iff (reset)
    (load && selected && !write_n) |=> op1 == OP_WRITE)
    else $error("write start not registered");
  a_sleep_enter: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(sleep_request) ##1 sleep_request |=> asleep)
    else $error("sleep not entered two cycles after request");
  a_stall_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (drive_reg && clock_gate_n && !asleep) |=> drive_reg)
    else $error("stalled read released the bus");

  c_pipe_read: cover property (@(posedge ref_clk) disable iff (reset)
    flow_mode_sel_n && next_op == OP_READ ##2 data_oe);
  c_flow_write: cover property (@(posedge ref_clk) disable iff (reset)
    !flow_mode_sel_n && next_op == OP_WRITE);
  c_burst: cover property (@(posedge ref_clk) disable iff (reset)
    step [*3]);
  c_sleep: cover property (@(posedge ref_clk) disable iff (reset)
    $rose(asleep));
endmodule

// >>> test/host_ctrl_model.sv
`timescale 1ns/1ps
// Memory controller that drives the command pins from the falling edge.
module host_ctrl_model
  import sram_pkg::*;
(
  // Clock and mode.
  input  wire logic              ref_clk,
  input  wire logic              flow_mode_sel_n,
  // Command and data pins.
  output logic                   clock_gate_n,
  output logic                   advance_load,
  output logic                   write_n,
  output logic                   chip_select_first_n,
  output logic                   chip_select_second,
  output logic                   chip_select_third_n,
  output logic [ADDR_W-1:0]      addr,
  output logic                   lane_strobe_first_n,
  output logic                   lane_strobe_second_n,
  output logic                   lane_strobe_third_n,
  output logic                   lane_strobe_fourth_n,
  output logic [DATA_W-1:0]      data_in
);
  logic              wd_v [0:2];
  logic [DATA_W-1:0] wd   [0:2];
  // Start deselected with the gate open and no write data queued.
  initial begin
    {clock_gate_n, advance_load, write_n} = 3'b001;
    {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'b101;
    addr = '0;
    {lane_strobe_fourth_n, lane_strobe_third_n, lane_strobe_second_n, lane_strobe_first_n} = 4'hf;
    data_in = '0;
    wd_v = '{1'b0, 1'b0, 1'b0};
  end
  // One bus cycle: move queued write data, then present the next command.
  task automatic step(input logic g, ld_n, wr, input logic [2:0] sel,
                      input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
                      input logic [DATA_W-1:0] d);
    @(negedge ref_clk);
    // Gated edges do not count toward the late-write slot.
    if (!clock_gate_n) begin
      wd_v = '{wd_v[1], wd_v[2], 1'b0};
      wd = '{wd[1], wd[2], wd[2]};
    end
    // Outside its slot the data line toggles so a stale value never passes.
    data_in = wd_v[0] ? wd[0] : ~data_in;
    clock_gate_n = g;
    advance_load = ld_n;
    write_n = !wr;
    {chip_select_first_n, chip_select_second, chip_select_third_n} = {!sel[0], sel[1], !sel[2]};
    addr = a;
    {lane_strobe_fourth_n, lane_strobe_third_n, lane_strobe_second_n, lane_strobe_first_n} = ln;
    if (!g && wr) begin
      wd_v[flow_mode_sel_n ? 2 : 1] = 1'b1;
      wd[flow_mode_sel_n ? 2 : 1] = d;
    end
  endtask
endmodule

// >>> test/tb_sync_late_write_sram_port.sv
`timescale 1ns/1ps
module tb_sync_late_write_sram_port;
  import sram_pkg::*;
  logic              ref_clk, reset, clock_gate_n, advance_load, write_n, data_oe;
  logic              chip_select_first_n, chip_select_second, chip_select_third_n;
  logic              lane_strobe_first_n, lane_strobe_second_n, lane_strobe_third_n;
  logic              lane_strobe_fourth_n, flow_mode_sel_n, linear_order_sel_n, sleep_request;
  logic              output_enable_n, burst_act, burst_wr, last_gate, asleep_exp;
  logic [ADDR_W-1:0] addr, base;
  logic [DATA_W-1:0] data_in, data_out;
  logic [DATA_W-1:0] mem  [0:63];
  logic [DATA_W-1:0] ex_d [0:2];
  logic              ex_v [0:2];
  logic [1:0]        cnt;
  int                fail_count = 0, samples_checked = 0;
  // Reference clock at 25 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  host_ctrl_model u_host (.ref_clk, .flow_mode_sel_n, .clock_gate_n, .advance_load,
    .write_n, .chip_select_first_n, .chip_select_second, .chip_select_third_n, .addr,
    .lane_strobe_first_n, .lane_strobe_second_n, .lane_strobe_third_n,
    .lane_strobe_fourth_n, .data_in);
  sync_late_write_sram_port u_dut (.ref_clk, .reset, .clock_gate_n, .advance_load,
    .write_n, .chip_select_first_n, .chip_select_second, .chip_select_third_n, .addr,
    .lane_strobe_first_n, .lane_strobe_second_n, .lane_strobe_third_n,
    .lane_strobe_fourth_n, .flow_mode_sel_n, .linear_order_sel_n, .sleep_request,
    .output_enable_n, .data_in, .data_out, .data_oe);
  // Low address bits of the n-th access of a burst.
  function automatic logic [1:0] burst_low(input logic [1:0] s, c, input logic lin_n);
    return lin_n ? (s ^ c) : (s + c);
  endfunction
  // Old word with the enabled lanes replaced.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, d,
                                              input logic [LANES-1:0] ln);
    for (int i = 0; i < LANES; i++) if (!ln[i]) o[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    return o;
  endfunction
  task automatic err(input string msg);
    fail_count++;
    $display("ERROR t=%0t %s", $time, msg);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One cycle: issue a command, track expected memory and read slots, check the bus.
  task automatic step(input logic g, ld_n, wr, input logic [2:0] sel,
                      input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln);
    logic [DATA_W-1:0] d;
    logic [ADDR_W-1:0] ea;
    logic              act;
    d = DATA_W'({$urandom(), $urandom()});
    u_host.step(g, ld_n, wr, sel, a, ln, d);
    output_enable_n = ($urandom_range(7) == 0);
    if (!last_gate) begin
      ex_v = '{ex_v[1], ex_v[2], 1'b0};
      ex_d = '{ex_d[1], ex_d[2], ex_d[2]};
    end
    last_gate = g;
    act = !g && !asleep_exp;
    if (act && !ld_n) begin
      burst_act = (sel == 3'b111);
      burst_wr = wr;
      base = a;
      cnt = 2'h0;
    end else if (act && burst_act) cnt = cnt + 2'h1;
    ea = {base[ADDR_W-1:2], burst_low(base[1:0], cnt, linear_order_sel_n)};
    if (act && burst_act && burst_wr) mem[ea[5:0]] = merge(mem[ea[5:0]], d, ln);
    if (act && burst_act && !burst_wr) begin
      ex_v[flow_mode_sel_n ? 2 : 1] = 1'b1;
      ex_d[flow_mode_sel_n ? 2 : 1] = mem[ea[5:0]];
    end
    #1;
    samples_checked += 2;
    if (ex_v[0] && data_oe !== !output_enable_n) err("bus enable wrong in read slot");
    if (!ex_v[0] && data_oe !== 1'b0) err("bus driven outside read slot");
    if (ex_v[0] && data_out !== ex_d[0]) err("read data mismatch");
  endtask
  initial begin
    logic g;
    void'($urandom(32'h4011));
    {reset, sleep_request, output_enable_n, linear_order_sel_n, asleep_exp} = 5'b10000;
    for (int m = 0; m < 2; m++) begin
      flow_mode_sel_n = (m == 0);
      reset = 1'b1;
      {ex_v[0], ex_v[1], ex_v[2], last_gate, burst_act} = 5'b0;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      for (int i = 0; i < 64; i++) step(0, 0, 1, 3'b111, ADDR_W'(i), 4'h0);
      for (int lo = 0; lo < 2; lo++) begin
        linear_order_sel_n = lo[0];
        step(0, 0, 0, 3'b111, ADDR_W'($urandom_range(31)), 4'hf);
        repeat (4) step(0, 1, 0, 3'b111, '1, 4'hf);
      end
      // Random back-to-back mix with stalls, deselects and partial lanes.
      repeat (300) begin
        g = ($urandom_range(7) == 0);
        case ($urandom_range(3))
          0: step(g, 0, 0, 3'b111, ADDR_W'($urandom_range(31)), 4'hf);
          1: step(g, 0, 1, 3'b111, ADDR_W'(32 + $urandom_range(31)), 4'($urandom_range(15)));
          2: step(g, 1, burst_wr, 3'b111, '1, 4'($urandom_range(15)));
          default: step(g, 0, 1'($urandom_range(1)), 3'($urandom_range(6)), '0, 4'h0);
        endcase
      end
      repeat (2) step(0, 0, 0, 3'b000, '0, 4'hf);
      for (int i = 32; i < 64; i++) step(0, 0, 0, 3'b111, ADDR_W'(i), 4'hf);
      repeat (3) step(0, 0, 0, 3'b000, '0, 4'hf);
      // Sleep: commands ignored two edges after the request, honoured two after release.
      sleep_request = 1'b1;
      step(0, 0, 0, 3'b000, '0, 4'hf);
      asleep_exp = 1'b1;
      step(0, 0, 1, 3'b111, '0, 4'h0);
      repeat (3) step(0, 0, 0, 3'b111, '0, 4'hf);
      sleep_request = 1'b0;
      step(0, 0, 0, 3'b000, '0, 4'hf);
      asleep_exp = 1'b0;
      step(0, 0, 0, 3'b111, '0, 4'hf);
      repeat (3) step(0, 0, 0, 3'b000, '0, 4'hf);
    end
    stop_test();
  end
endmodule
